//--- stm_pkg.sv
// Package: register map, field positions and enumerations of the standard timer
package stm_pkg;
  // ----------------------------------------
  // Register byte addresses (one word each)
  // ----------------------------------------
  localparam logic [4:0] STM_ADDR_CTRL0 = 5'h00;
  localparam logic [4:0] STM_ADDR_MODE_CTRL = 5'h04;
  localparam logic [4:0] STM_ADDR_CNT_LO = 5'h08;
  localparam logic [4:0] STM_ADDR_CNT_HI = 5'h0C;
  localparam logic [4:0] STM_ADDR_CMPA_LO = 5'h10;
  localparam logic [4:0] STM_ADDR_CMPA_HI = 5'h14;
  localparam logic [4:0] STM_ADDR_CMPP = 5'h18;
  localparam logic [4:0] STM_ADDR_FLAGS = 5'h1C;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int STM_CTRL0_ON_BIT = 3;
  localparam int STM_MODE_HI = 7;
  localparam int STM_MODE_LO = 6;
  localparam int STM_FUNC_HI = 5;
  localparam int STM_FUNC_LO = 4;
  localparam int STM_INIT_BIT = 3;
  localparam int STM_INV_BIT = 2;
  localparam int STM_SWAP_BIT = 1;
  localparam int STM_CLR_BIT = 0;
  localparam int STM_FLAG_A_BIT = 0;
  localparam int STM_FLAG_P_BIT = 1;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] STM_RST_BYTE = 8'h00;
  localparam logic [15:0] STM_RST_WORD = 16'h0000;
  localparam logic [31:0] STM_UNMAPPED_DATA = 32'h0000_0000;
  // ----------------------------------------
  // Modes and output functions
  // ----------------------------------------
  typedef enum logic [1:0] {
    STM_MODE_COMPARE = 2'h0,
    STM_MODE_CAPTURE = 2'h1,
    STM_MODE_PWM = 2'h2,
    STM_MODE_TIMER = 2'h3
  } stm_mode_e;
  localparam logic [1:0] STM_FN_00 = 2'h0;
  localparam logic [1:0] STM_FN_01 = 2'h1;
  localparam logic [1:0] STM_FN_10 = 2'h2;
  localparam logic [1:0] STM_FN_11 = 2'h3;
endpackage : stm_pkg

//--- stm_timer.sv
// Standard timer: 16-bit counter, comparators A and P, output stage, Wishbone slave
`timescale 1ns/10ps
// Behaviour
// - Mode field: compare, capture, PWM/pulse, timer.
// - 16-bit up-counter runs while counter_on set.
// - counter_on rise zeroes counter; fall holds.
// - Low byte passes through holding buffer.
// - Compare mode A match: none/low/high/toggle.
// - PWM mode: inactive, active, PWM, pulse.
// - Capture on rising, falling, both, never.
// - Match to same level leaves pin unchanged.
// - counter_on rise restores initial pin level.
// - Control bit: initial level or active level.
// - Invert bit flips pin; not in timer.
// - Swap bit exchanges period and duty sources.
// - Clear source: A match, else P/overflow.
// - Overflow clear only when P value zero.
// - Clear source ignored outside compare/timer modes.
// - Counter read as two read-only bytes.
// - Compare A held in two RW bytes.
// - P compares counter[15:8]; zero means 65536.
// - Code 00 selects compare-match output mode.
// - Clear source 0 raises both flags.
// - Clear source 1 never raises P flag in compare/timer modes.
// - In compare mode only A matches move the output pin.
// ----------------------------------------
// Limitations
// ----------------------------------------
// The counter steps on every clk_i edge; clock-source choice and pause are not modelled.
// Bus writes commit at the edge where the master sees ack; reads load data a cycle earlier.
// The capture pin passes two flip-flops, so a capture lands three edges after the pin moves.
// The output pin is registered, so it trails the internal level by one edge.
// Changing the mode or function while counting gives no defined waveform.
module stm_timer
  import stm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic capture_pin_i,
  output logic timer_out_o,
  output logic timer_out_n_o,
  output logic match_a_flag_o,
  output logic match_p_flag_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic counter_on_q;
  logic on_prev_q;
  logic [7:0] mode_ctrl_q;
  logic [15:0] count_q;
  logic [15:0] cmpa_q;
  logic [7:0] cmpp_q;
  logic [7:0] hold_q;
  logic match_a_flag_q;
  logic match_p_flag_q;
  logic pin_q;
  logic pwm_q;
  logic cap_s1_q;
  logic cap_s2_q;
  logic cap_prev_q;
  logic ack_q;
  logic [31:0] rdat_q;
  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  wire [1:0] mode_sel = mode_ctrl_q[STM_MODE_HI:STM_MODE_LO];
  wire [1:0] func_sel = mode_ctrl_q[STM_FUNC_HI:STM_FUNC_LO];
  wire init_level = mode_ctrl_q[STM_INIT_BIT];
  wire out_inv = mode_ctrl_q[STM_INV_BIT];
  wire swap = mode_ctrl_q[STM_SWAP_BIT];
  wire clr_sel = mode_ctrl_q[STM_CLR_BIT];
  wire mode_cmp = mode_sel == STM_MODE_COMPARE;
  wire mode_cap = mode_sel == STM_MODE_CAPTURE;
  wire mode_pwm = mode_sel == STM_MODE_PWM;
  wire mode_tmr = mode_sel == STM_MODE_TIMER;
  wire cmp_like = mode_cmp | mode_tmr;
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  // Writes commit at the edge where the master samples ack, as classic Wishbone expects
  wire wr = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];
  wire rd = req & ~wb_we_i;
  wire [7:0] wbyte = wb_dat_i[7:0];
  wire wr_ctrl0 = wr & (wb_adr_i == STM_ADDR_CTRL0);
  wire wr_mode = wr & (wb_adr_i == STM_ADDR_MODE_CTRL);
  wire wr_alo = wr & (wb_adr_i == STM_ADDR_CMPA_LO);
  wire wr_ahi = wr & (wb_adr_i == STM_ADDR_CMPA_HI);
  wire wr_p = wr & (wb_adr_i == STM_ADDR_CMPP);
  wire wr_flags = wr & (wb_adr_i == STM_ADDR_FLAGS);
  wire rd_cnt_hi = rd & (wb_adr_i == STM_ADDR_CNT_HI);
  wire rd_a_hi = rd & (wb_adr_i == STM_ADDR_CMPA_HI);
  // ----------------------------------------
  // Comparators
  // ----------------------------------------
  // rising edge of counter_on
  wire on_rise = counter_on_q & ~on_prev_q;
  wire match_a = counter_on_q & (count_q == cmpa_q);
  // P compares the top byte only, at the end of each 256-count block
  wire p_hit = (cmpp_q != STM_RST_BYTE) & (count_q[15:8] == cmpp_q) & (count_q[7:0] == 8'hFF);
  // zero P value means overflow at full scale
  wire ovf_hit = (cmpp_q == STM_RST_BYTE) & (count_q == 16'hFFFF);
  wire match_p = counter_on_q & (p_hit | ovf_hit);
  wire pwm_period_end = swap ? match_a : match_p;
  wire [16:0] duty_val = swap ? ((cmpp_q == STM_RST_BYTE) ? 17'h10000 : {1'b0, cmpp_q, 8'h00})
                              : {1'b0, cmpa_q};
  wire duty_active = {1'b0, count_q} < duty_val;
  // clear source only steers compare and timer modes
  wire clr_cmp = clr_sel ? match_a : match_p;
  wire pulse_end = mode_pwm & (func_sel == STM_FN_11) & match_a;
  wire count_clr = cmp_like ? clr_cmp :
                   mode_cap ? match_p :
                   (mode_pwm & (func_sel != STM_FN_11)) ? pwm_period_end : 1'b0;
  // P flag suppressed when A clears the counter in compare/timer modes, and in pulse mode
  wire set_p = match_p & ~(cmp_like & clr_sel) & ~(mode_pwm & (func_sel == STM_FN_11));
  // capture edge select on synchronised pin
  wire cap_rise = cap_s2_q & ~cap_prev_q;
  wire cap_fall = ~cap_s2_q & cap_prev_q;
  logic cap_take;
  always_comb begin
    unique case (func_sel)
      STM_FN_00: cap_take = cap_rise;
      STM_FN_01: cap_take = cap_fall;
      STM_FN_10: cap_take = cap_rise | cap_fall;
      STM_FN_11: cap_take = 1'b0;
    endcase
  end
  wire capture = mode_cap & counter_on_q & cap_take;
  wire set_a = (match_a & ~mode_cap) | capture;
  // ----------------------------------------
  // Compare output level
  // ----------------------------------------
  // set/clear to a level already held changes nothing
  logic pin_d;
  always_comb begin
    unique case (func_sel)
      STM_FN_00: pin_d = pin_q;
      STM_FN_01: pin_d = 1'b0;
      STM_FN_10: pin_d = 1'b1;
      STM_FN_11: pin_d = ~pin_q;
    endcase
  end
  // PWM/pulse output uses control bit as active level
  logic pwm_level;
  always_comb begin
    unique case (func_sel)
      STM_FN_00: pwm_level = ~init_level;
      STM_FN_01: pwm_level = init_level;
      STM_FN_10: pwm_level = (duty_active & counter_on_q) ? init_level : ~init_level;
      STM_FN_11: pwm_level = counter_on_q ? init_level : ~init_level;
    endcase
  end
  wire raw_out = mode_pwm ? pwm_level : pin_q;
  wire final_out = (out_inv & ~mode_tmr) ? ~raw_out : raw_out;
  // ----------------------------------------
  // Control and counter
  // ----------------------------------------
  // Pulse end drops counter_on; a software write in the same cycle wins
  wire on_wr_val = wbyte[STM_CTRL0_ON_BIT];
  logic counter_on_d;
  always_comb begin
    counter_on_d = counter_on_q;
    if (wr_ctrl0) begin
      counter_on_d = on_wr_val;
    end else if (pulse_end) begin
      counter_on_d = 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_on_q <= 1'b0;
    end else begin
      counter_on_q <= counter_on_d;
    end
  end
  // previous counter_on, for the restart edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_prev_q <= 1'b0;
    end else begin
      on_prev_q <= counter_on_q;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ctrl_q <= STM_RST_BYTE;
    end else if (wr_mode) begin
      mode_ctrl_q <= wbyte;
    end
  end
  // next count: restart from zero, clear on match, or step by one
  wire [15:0] count_inc = count_q + 16'h0001;
  logic [15:0] count_d;
  always_comb begin
    count_d = count_q;
    if (on_rise) begin
      count_d = STM_RST_WORD;
    end else if (counter_on_q) begin
      count_d = count_clr ? STM_RST_WORD : count_inc;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= STM_RST_WORD;
    end else begin
      count_q <= count_d;
    end
  end
  // ----------------------------------------
  // Compare values, holding buffer
  // ----------------------------------------
  // capture loads compare A in capture mode and beats a bus write
  // low byte latched from buffer on high write
  logic [15:0] cmpa_d;
  always_comb begin
    cmpa_d = cmpa_q;
    if (capture) begin
      cmpa_d = count_q;
    end else if (wr_ahi) begin
      cmpa_d = {wbyte, hold_q};
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmpa_q <= STM_RST_WORD;
    end else begin
      cmpa_q <= cmpa_d;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmpp_q <= STM_RST_BYTE;
    end else if (wr_p) begin
      cmpp_q <= wbyte;
    end
  end
  // buffer filled on low write or high read
  logic [7:0] hold_d;
  always_comb begin
    hold_d = hold_q;
    if (wr_alo) begin
      hold_d = wbyte;
    end else if (rd_cnt_hi) begin
      hold_d = count_q[7:0];
    end else if (rd_a_hi) begin
      hold_d = cmpa_q[7:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= STM_RST_BYTE;
    end else begin
      hold_q <= hold_d;
    end
  end
  // ----------------------------------------
  // Flags and output pin
  // ----------------------------------------
  // set wins over a write-one clear
  wire clr_a = wr_flags & wbyte[STM_FLAG_A_BIT];
  wire clr_p = wr_flags & wbyte[STM_FLAG_P_BIT];
  wire match_a_flag_d = set_a | (match_a_flag_q & ~clr_a);
  wire match_p_flag_d = set_p | (match_p_flag_q & ~clr_p);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_a_flag_q <= 1'b0;
    end else begin
      match_a_flag_q <= match_a_flag_d;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_p_flag_q <= 1'b0;
    end else begin
      match_p_flag_q <= match_p_flag_d;
    end
  end
  // restore initial level on restart; park it while stopped outside compare mode
  wire pin_restore = on_rise | (~counter_on_q & ~mode_cmp);
  // only A matches move the pin in compare mode
  wire pin_move = mode_cmp & match_a;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= 1'b0;
    end else if (pin_restore) begin
      pin_q <= init_level;
    end else if (pin_move) begin
      pin_q <= pin_d;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= final_out;
    end
  end
  // Two-flop synchroniser; only the second stage feeds the edge detector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_s1_q <= 1'b0;
      cap_s2_q <= 1'b0;
    end else begin
      cap_s1_q <= capture_pin_i;
      cap_s2_q <= cap_s1_q;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_prev_q <= 1'b0;
    end else begin
      cap_prev_q <= cap_s2_q;
    end
  end
  // ----------------------------------------
  // Wishbone read path
  // ----------------------------------------
  logic [31:0] rsel;
  always_comb begin
    rsel = STM_UNMAPPED_DATA;
    unique case (wb_adr_i)
      STM_ADDR_CTRL0: rsel[STM_CTRL0_ON_BIT] = counter_on_q;
      STM_ADDR_MODE_CTRL: rsel[7:0] = mode_ctrl_q;
      // low bytes come through the holding buffer
      STM_ADDR_CNT_LO: rsel[7:0] = hold_q;
      STM_ADDR_CNT_HI: rsel[7:0] = count_q[15:8];
      STM_ADDR_CMPA_LO: rsel[7:0] = hold_q;
      STM_ADDR_CMPA_HI: rsel[7:0] = cmpa_q[15:8];
      STM_ADDR_CMPP: rsel[7:0] = cmpp_q;
      STM_ADDR_FLAGS: rsel[1:0] = {match_p_flag_q, match_a_flag_q};
      default: rsel = STM_UNMAPPED_DATA;
    endcase
  end
  // Every address acks so an unmapped access never hangs the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end
  // Read data is loaded when the request is taken and stands until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= STM_UNMAPPED_DATA;
    end else if (rd) begin
      rdat_q <= rsel;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign timer_out_o = pwm_q;
  assign timer_out_n_o = ~pwm_q;
  assign match_a_flag_o = match_a_flag_q;
  assign match_p_flag_o = match_p_flag_q;
endmodule : stm_timer

//--- stm_timer_monitor.sv
// Checker of the standard timer port behaviour
`timescale 1ns/10ps
module stm_timer_chk
  import stm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic capture_pin_i,
  input wire logic timer_out_o,
  input wire logic timer_out_n_o,
  input wire logic match_a_flag_o,
  input wire logic match_p_flag_o
);
  // ----
  // Properties
  // ----
  logic wr_flags;
  assign wr_flags = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] &&
    wb_adr_i == STM_ADDR_FLAGS;
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_needs_request: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_pins_opposite: assert property (timer_out_n_o != timer_out_o)
    else $error("pins not inverse");
  a_flag_a_held: assert property (
    $fell(match_a_flag_o) |-> $past(wr_flags && wb_dat_i[0])) else $error("A flag lost");
  a_flag_p_held: assert property (
    $fell(match_p_flag_o) |-> $past(wr_flags && wb_dat_i[1])) else $error("P flag lost");
  a_reset_quiet_outputs: assert property (
    $fell(rst_i) |-> !wb_ack_o && !match_a_flag_o && !match_p_flag_o) else $error("reset state");
endmodule : stm_timer_chk

//--- stm_pin_model.sv
// Pin partner: source of the capture input
`timescale 1ns/10ps
module stm_pin_model (
  input wire logic clk_i,
  input wire logic level_i,
  output logic capture_pin_o
);
  // Edges leave just after a clk_i edge, in step with the timer's own sampling clock
  always_ff @(posedge clk_i) begin
    capture_pin_o <= level_i;
  end
endmodule : stm_pin_model

//--- stm_timer_tb_top.sv
// Testbench of the standard timer
`timescale 1ns/10ps
module stm_timer_tb_top;
  import stm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic lvl = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [7:0] rv;
  logic ack, tout, tout_n, fa, fp, cap;
  int err_count = 0;
  int checks_done = 0;
  always #2.5 clk_i = ~clk_i;
  stm_timer i_stm_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .capture_pin_i(cap), .timer_out_o(tout), .timer_out_n_o(tout_n),
    .match_a_flag_o(fa), .match_p_flag_o(fp));
  stm_pin_model i_stm_pin_model (.clk_i(clk_i), .level_i(lvl), .capture_pin_o(cap));
  // ----
  // Bus and compare tasks
  // ----
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_bit(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rv = rdat[7:0];
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
    wb(1'b0, a, 8'h00);
    chk(nm, e, rv);
  endtask : rd
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    for (int a = 0; a < 32; a += 2) rd(a[4:0], 8'h00, "reset");
    wr(STM_ADDR_CMPA_LO, 8'h34);
    wr(STM_ADDR_CMPA_HI, 8'h12);
    wr(STM_ADDR_CMPA_LO, 8'h56);
    rd(STM_ADDR_CMPA_HI, 8'h12, "cmpa hi");
    rd(STM_ADDR_CMPA_LO, 8'h34, "cmpa lo");
    wr(STM_ADDR_CNT_HI, 8'hFF);
    rd(STM_ADDR_CNT_HI, 8'h00, "cnt ro");
  endtask : t_regs
  task automatic t_cmp();
    logic e;
    int n;
    wr(STM_ADDR_CMPA_LO, 8'h10);
    wr(STM_ADDR_CMPA_HI, 8'h02);
    wr(STM_ADDR_CMPP, 8'h01);
    for (int k = 0; k < 16; k++) begin
      wr(STM_ADDR_CTRL0, 8'h00);
      wr(STM_ADDR_MODE_CTRL, {2'b00, k[1:0], k[2], k[3], 2'b01});
      wr(STM_ADDR_FLAGS, 8'h03);
      wr(STM_ADDR_CTRL0, 8'h08);
      repeat (2) @(posedge clk_i);
      chk_bit("start", k[2] ^ k[3], tout);
      n = 0;
      while (fa !== 1'b1 && n < 600) begin
        @(posedge clk_i);
        n++;
      end
      repeat (3) @(posedge clk_i);
      e = (k[1:0] == 2'b00) ? k[2] : (k[1:0] == 2'b11) ? !k[2] : k[1];
      chk_bit("match", e ^ k[3], tout);
      chk_bit("p flag", 1'b0, fp);
      chk_bit("a flag", 1'b1, fa);
    end
  endtask : t_cmp
  task automatic t_clr0();
    wr(STM_ADDR_CTRL0, 8'h00);
    wr(STM_ADDR_CMPA_LO, 8'h00);
    wr(STM_ADDR_CMPA_HI, 8'h01);
    wr(STM_ADDR_MODE_CTRL, 8'h30);
    wr(STM_ADDR_FLAGS, 8'h03);
    wr(STM_ADDR_CTRL0, 8'h08);
    repeat (300) @(posedge clk_i);
    chk_bit("toggle", 1'b1, tout);
    repeat (200) @(posedge clk_i);
    chk_bit("p early", 1'b0, fp);
    repeat (40) @(posedge clk_i);
    chk_bit("p flag", 1'b1, fp);
    chk_bit("a flag", 1'b1, fa);
    chk_bit("p pin", 1'b1, tout);
    repeat (260) @(posedge clk_i);
    chk_bit("retoggle", 1'b0, tout);
    wr(STM_ADDR_CTRL0, 8'h00);
    repeat (300) @(posedge clk_i);
    rd(STM_ADDR_CNT_HI, 8'h01, "held");
    wr(STM_ADDR_CTRL0, 8'h08);
    wr(STM_ADDR_CTRL0, 8'h00);
    rd(STM_ADDR_CNT_HI, 8'h00, "zeroed");
  endtask : t_clr0
  task automatic t_cap();
    for (int f = 0; f < 4; f++) begin
      wr(STM_ADDR_CTRL0, 8'h00);
      wr(STM_ADDR_MODE_CTRL, {2'b01, f[1:0], 4'h0});
      wr(STM_ADDR_FLAGS, 8'h03);
      wr(STM_ADDR_CTRL0, 8'h08);
      lvl <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk_bit("rise", f == 0 || f == 2, fa);
      wr(STM_ADDR_FLAGS, 8'h01);
      lvl <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk_bit("fall", f == 1 || f == 2, fa);
    end
  endtask : t_cap
  task automatic t_pwm();
    for (int k = 0; k < 4; k++) begin
      wr(STM_ADDR_CTRL0, 8'h00);
      wr(STM_ADDR_MODE_CTRL, {3'b100, k[0], k[1], 3'b000});
      wr(STM_ADDR_CTRL0, 8'h08);
      repeat (3) @(posedge clk_i);
      chk_bit("forced", ~(k[0] ^ k[1]), tout);
    end
  endtask : t_pwm
  task automatic t_wave();
    for (int s = 0; s < 2; s++) begin
      wr(STM_ADDR_CTRL0, 8'h00);
      wr(STM_ADDR_CMPA_LO, (s == 1) ? 8'h00 : 8'h40);
      wr(STM_ADDR_CMPA_HI, (s == 1) ? 8'h03 : 8'h00);
      wr(STM_ADDR_MODE_CTRL, {2'b10, 2'b10, 1'b1, 1'b0, s[0], 1'b0});
      wr(STM_ADDR_CTRL0, 8'h08);
      repeat (20) @(posedge clk_i);
      chk_bit("duty on", 1'b1, tout);
      repeat ((s == 1) ? 400 : 100) @(posedge clk_i);
      chk_bit("duty off", 1'b0, tout);
    end
  endtask : t_wave
  task automatic t_pulse();
    wr(STM_ADDR_CTRL0, 8'h00);
    wr(STM_ADDR_CMPA_LO, 8'h20);
    wr(STM_ADDR_CMPA_HI, 8'h00);
    wr(STM_ADDR_MODE_CTRL, 8'hB8);
    wr(STM_ADDR_FLAGS, 8'h03);
    wr(STM_ADDR_CTRL0, 8'h08);
    repeat (5) @(posedge clk_i);
    chk_bit("pulse on", 1'b1, tout);
    repeat (60) @(posedge clk_i);
    chk_bit("pulse off", 1'b0, tout);
    chk_bit("pulse flag", 1'b1, fa);
    rd(STM_ADDR_CTRL0, 8'h00, "pulse stop");
  endtask : t_pulse
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_cmp();
    t_clr0();
    t_cap();
    t_pwm();
    t_wave();
    t_pulse();
    finish_test();
  end
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
endmodule : stm_timer_tb_top
bind stm_timer stm_timer_chk i_stm_timer_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .capture_pin_i(capture_pin_i), .timer_out_o(timer_out_o), .timer_out_n_o(timer_out_n_o),
  .match_a_flag_o(match_a_flag_o), .match_p_flag_o(match_p_flag_o));
